// *** hw/bpc_pkg.sv ***
// package for the bidirectional port with change interrupt
package bpc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PORT_W = 8;
    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_PORT_DATA = 8'h06;
    localparam logic [7:0] IDX_CONFIG = 8'h81;
    localparam logic [7:0] IDX_DIRECTION = 8'h86;
    localparam logic [7:0] IDX_INT_CTRL = 8'h0b;
    localparam logic [7:0] IDX_SYS_CTRL = 8'h0c;
    localparam int PULLUP_BAR_BIT = 7;
    localparam int CHANGE_FLAG_BIT = 0;
    localparam int CHANGE_LO = 4;
    localparam int CHANGE_HI = 7;
    localparam int PROG_PIN = 4;
    localparam int SYS_LVP_BIT = 0;
    localparam int SYS_SLEEP_BIT = 1;
    localparam logic [7:0] CONFIG_RST = 8'hff;
    localparam logic [7:0] DIR_RST = 8'hff;
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
    typedef enum logic [1:0] {BPC_IDLE, BPC_ANSWER} bpc_bus_type;
endpackage

// *** hw/bpc_port.sv ***
// bidirectional port with per-pin direction, pull-ups and upper-pin change flag
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/100ps
// Function
// - 8 pins; direction 1 tristates, 0 drives
// - alternate function may override pin direction
// - data read returns pins, write hits latch
// - writes are read-modify-write into whole latch
// - shared pull-up enable, active low bit 7
// - pull-up off on any output pin
// - power-on reset disables pull-ups
// - change detect pins 7:4, inputs only
// - compare inputs against value from last data access
// - mismatches ORed into change flag bit 0
// - change flag wakes device from sleep
// - data access refreshes comparison values
// - mismatch keeps setting flag until data access
// - change during read may miss flag
// - low-voltage programming steals pin 4
// - reset values: direction and config all ones
// - pins shared with peripheral functions
// - write at cycle end, read samples start
module bpc_port
    import bpc_pkg::*;
(
    input wire logic I_CORE_CLK, // instruction clock
    input wire logic I_RST, // async reset, active high
    input wire logic I_POR, // power-on reset indication, level
    input wire logic [bpc_pkg::ADDR_W-1:0] I_AVS_ADDRESS, // word address
    input wire logic I_AVS_READ, // read request
    input wire logic I_AVS_WRITE, // write request
    input wire logic [bpc_pkg::DATA_W-1:0] I_AVS_WRITEDATA, // write data
    input wire logic [3:0] I_AVS_BYTEENABLE, // byte enables
    output logic [bpc_pkg::DATA_W-1:0] O_AVS_READDATA, // read data
    output logic O_AVS_WAITREQUEST, // stall
    input wire logic [bpc_pkg::PORT_W-1:0] I_PIN, // pin levels
    output logic [bpc_pkg::PORT_W-1:0] O_PIN, // pin drive values
    output logic [bpc_pkg::PORT_W-1:0] O_PIN_OE_N, // low while driving
    output logic [bpc_pkg::PORT_W-1:0] O_PULLUP_EN, // weak pull-up on
    input wire logic [bpc_pkg::PORT_W-1:0] I_ALT_EN, // alternate function owns pin
    input wire logic [bpc_pkg::PORT_W-1:0] I_ALT_OUT, // alternate output value
    input wire logic [bpc_pkg::PORT_W-1:0] I_ALT_OE, // alternate drives pin
    output logic [bpc_pkg::PORT_W-1:0] O_ALT_IN, // synced pins to peripherals
    output logic O_CHANGE_FLAG, // port change flag
    output logic O_WAKE, // wake request
    output logic O_LVP_ACTIVE // pin 4 is programming input
);
    import bpc_pkg::*;

    // ****************************************
    // pin synchroniser
    // ****************************************
    logic [PORT_W-1:0] sync1_q;
    logic [PORT_W-1:0] pins_q;
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            sync1_q <= '0;
            pins_q <= '0;
        end else begin
            sync1_q <= I_PIN;
            pins_q <= sync1_q;
        end
    end
    assign O_ALT_IN = pins_q;

    // ****************************************
    // bus slave
    // ****************************************
    bpc_bus_type bus_q;
    logic [PORT_W-1:0] latch_q;
    logic [PORT_W-1:0] dir_q;
    logic [PORT_W-1:0] cfg_q;
    logic [PORT_W-1:0] old_q;
    logic flag_q;
    logic lvp_q;
    logic sleep_q;
    logic por_seen_q;
    logic req;
    logic take;
    logic hit_data;
    logic [PORT_W-1:0] wbyte;

    function automatic logic [PORT_W-1:0] merge(input logic [PORT_W-1:0] base,
                                                input logic [DATA_W-1:0] wd,
                                                input logic be0);
        merge = be0 ? wd[PORT_W-1:0] : base;
    endfunction

    assign req = I_AVS_READ | I_AVS_WRITE;
    // one wait cycle: the answer comes in the second cycle of the request
    assign take = req && (bus_q == BPC_ANSWER);
    assign O_AVS_WAITREQUEST = req && (bus_q == BPC_IDLE);
    assign hit_data = take && (I_AVS_ADDRESS == IDX_PORT_DATA);
    assign wbyte = I_AVS_WRITEDATA[PORT_W-1:0];

    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            bus_q <= BPC_IDLE;
        end else begin
            case (bus_q)
                BPC_IDLE: begin
                    if (req) begin
                        bus_q <= BPC_ANSWER;
                    end
                end
                default: begin
                    bus_q <= BPC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_AVS_READDATA <= '0;
        // read samples pins at the start of the request; data stands while waitrequest is low
        end else if (req && (bus_q == BPC_IDLE) && I_AVS_READ) begin
            if (I_AVS_ADDRESS == IDX_PORT_DATA) begin
                O_AVS_READDATA <= {{(DATA_W-PORT_W){1'b0}}, pins_q};
            end else if (I_AVS_ADDRESS == IDX_CONFIG) begin
                O_AVS_READDATA <= {{(DATA_W-PORT_W){1'b0}}, cfg_q};
            end else if (I_AVS_ADDRESS == IDX_DIRECTION) begin
                O_AVS_READDATA <= {{(DATA_W-PORT_W){1'b0}}, dir_q};
            end else if (I_AVS_ADDRESS == IDX_INT_CTRL) begin
                O_AVS_READDATA <= {{(DATA_W-1){1'b0}}, flag_q};
            end else if (I_AVS_ADDRESS == IDX_SYS_CTRL) begin
                O_AVS_READDATA <= {{(DATA_W-2){1'b0}}, sleep_q, lvp_q};
            end else begin
                O_AVS_READDATA <= UNMAPPED_DATA;
            end
        end
    end

    // ****************************************
    // latch, direction, config
    // ****************************************
    // latch keeps its value across non power-on resets; cleared on power-on only
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST && I_POR) begin
            latch_q <= LATCH_RST;
        end else if (!I_RST && hit_data && I_AVS_WRITE) begin
            latch_q <= merge(pins_q, I_AVS_WRITEDATA, I_AVS_BYTEENABLE[0]);
        end
    end

    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            dir_q <= DIR_RST;
            cfg_q <= CONFIG_RST;
            lvp_q <= 1'b0;
            sleep_q <= 1'b0;
        end else if (take && I_AVS_WRITE && I_AVS_BYTEENABLE[0]) begin
            if (I_AVS_ADDRESS == IDX_DIRECTION) begin
                dir_q <= wbyte;
            end else if (I_AVS_ADDRESS == IDX_CONFIG) begin
                cfg_q <= wbyte;
            end else if (I_AVS_ADDRESS == IDX_SYS_CTRL) begin
                lvp_q <= wbyte[SYS_LVP_BIT];
                sleep_q <= wbyte[SYS_SLEEP_BIT];
            end
        end else if (sleep_q && flag_q) begin
            sleep_q <= 1'b0;
        end
    end

    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            por_seen_q <= 1'b0;
        end else begin
            por_seen_q <= 1'b1;
        end
    end

    // ****************************************
    // pin drivers and pull-ups
    // ****************************************
    logic [PORT_W-1:0] is_out;
    logic [PORT_W-1:0] prog_mask;
    always_comb begin
        prog_mask = '0;
        prog_mask[PROG_PIN] = lvp_q;
        for (int i = 0; i < PORT_W; i++) begin
            is_out[i] = I_ALT_EN[i] ? I_ALT_OE[i] : !dir_q[i];
            is_out[i] = is_out[i] && !prog_mask[i];
        end
    end
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_PIN <= '0;
            O_PIN_OE_N <= '1;
            O_PULLUP_EN <= '0;
        end else begin
            for (int i = 0; i < PORT_W; i++) begin
                O_PIN[i] <= I_ALT_EN[i] ? I_ALT_OUT[i] : latch_q[i];
            end
            O_PIN_OE_N <= ~is_out;
            O_PULLUP_EN <= {PORT_W{!cfg_q[PULLUP_BAR_BIT] && por_seen_q}}
                           & ~is_out & ~prog_mask;
        end
    end
    assign O_LVP_ACTIVE = lvp_q;

    // ****************************************
    // change detection
    // ****************************************
    logic [PORT_W-1:0] part;
    logic mismatch;
    always_comb begin
        part = '0;
        for (int i = CHANGE_LO; i <= CHANGE_HI; i++) begin
            part[i] = !is_out[i];
        end
        part = part & ~prog_mask;
        mismatch = |((pins_q ^ old_q) & part);
    end

    // a change that lands on the refreshing access is absorbed into old_q
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            old_q <= '0;
        end else if (hit_data) begin
            old_q <= pins_q;
        end
    end

    logic mismatch_q;
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            mismatch_q <= 1'b0;
        end else begin
            mismatch_q <= mismatch && !hit_data;
        end
    end

    logic clr_flag;
    assign clr_flag = take && I_AVS_WRITE && I_AVS_BYTEENABLE[0]
                      && (I_AVS_ADDRESS == IDX_INT_CTRL)
                      && !wbyte[CHANGE_FLAG_BIT];
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            flag_q <= 1'b0;
        end else if (mismatch_q) begin
            flag_q <= 1'b1;
        end else if (clr_flag) begin
            flag_q <= 1'b0;
        end
    end
    assign O_CHANGE_FLAG = flag_q;
    assign O_WAKE = flag_q && sleep_q;

    // ****************************************
    // checks
    // ****************************************
    chk_flag_after_mismatch: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        mismatch && !hit_data |=> ##1 flag_q)
        else $error("flag not set after mismatch");
    chk_read_refresh_cmp: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        hit_data |=> old_q == $past(pins_q))
        else $error("comparison not refreshed");
    chk_output_no_pullup: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        is_out != '0 |=> (O_PULLUP_EN & $past(is_out)) == '0)
        else $error("pull-up on output pin");
    chk_dir_tristate: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        (I_ALT_EN == '0 && !lvp_q) |=> O_PIN_OE_N == $past(dir_q))
        else $error("drive enable not from direction");
    chk_write_rmw: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        hit_data && I_AVS_WRITE && I_AVS_BYTEENABLE[0] |=> latch_q == $past(wbyte))
        else $error("latch not written");
    chk_read_pins: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        hit_data && I_AVS_READ |-> O_AVS_READDATA[PORT_W-1:0] == $past(pins_q))
        else $error("read did not return pins");
    chk_flag_set_wins: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        mismatch_q && clr_flag |=> flag_q)
        else $error("clear beat set");
    chk_lower_no_change: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        part[CHANGE_LO-1:0] == '0)
        else $error("lower pin in change compare");
    chk_wake_sleep: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        sleep_q && flag_q |-> O_WAKE ##1 !sleep_q)
        else $error("no wake from sleep");
    chk_lvp_pin: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        lvp_q |=> !O_PULLUP_EN[PROG_PIN] && O_PIN_OE_N[PROG_PIN])
        else $error("programming pin not released");
    chk_wait_one: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        req && bus_q == BPC_IDLE |-> O_AVS_WAITREQUEST ##1 !O_AVS_WAITREQUEST)
        else $error("wait not one cycle");

    // ****************************************
    // named sequences and further checks
    // ****************************************
    sequence s_bus_start;
        req && bus_q == BPC_IDLE;
    endsequence

    sequence s_bus_answer;
        req && !O_AVS_WAITREQUEST;
    endsequence

    sequence s_mismatch_seen;
        mismatch && !hit_data;
    endsequence

    sequence s_flag_late;
        ##2 flag_q;
    endsequence

    sequence s_cfg_write;
        take && I_AVS_WRITE && I_AVS_BYTEENABLE[0] && I_AVS_ADDRESS == IDX_CONFIG;
    endsequence

    sequence s_dir_write;
        take && I_AVS_WRITE && I_AVS_BYTEENABLE[0] && I_AVS_ADDRESS == IDX_DIRECTION;
    endsequence

    chk_mismatch_flag_seq: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        s_mismatch_seen |-> s_flag_late)
        else $error("mismatch did not raise flag");

    chk_bus_two_step: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        s_bus_start |=> s_bus_answer)
        else $error("request not answered in second cycle");

    chk_config_write: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        s_cfg_write |=> cfg_q == $past(wbyte))
        else $error("config not written");

    chk_dir_write: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        s_dir_write |=> dir_q == $past(wbyte))
        else $error("direction not written");

    chk_flag_clear_ok: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        clr_flag && !mismatch_q |=> !flag_q)
        else $error("flag not cleared");

    chk_flag_hold: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        flag_q && !clr_flag |=> flag_q)
        else $error("flag dropped without clear");

    chk_flag_needs_cause: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        !flag_q && !mismatch_q |=> !flag_q)
        else $error("flag set without mismatch");

    chk_pullup_bar_off: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        cfg_q[PULLUP_BAR_BIT] |=> O_PULLUP_EN == '0)
        else $error("pull-up on while disabled");

    chk_pullup_input_on: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        !cfg_q[PULLUP_BAR_BIT] && !is_out[CHANGE_HI] && !prog_mask[CHANGE_HI]
        |=> O_PULLUP_EN[CHANGE_HI])
        else $error("pull-up off on enabled input");

    chk_no_wait_idle: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        !req |-> !O_AVS_WAITREQUEST)
        else $error("wait without request");

    chk_alt_drive: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        I_ALT_EN != '0 |=> ((~O_PIN_OE_N) & $past(I_ALT_EN & ~prog_mask))
        == $past(I_ALT_EN & I_ALT_OE & ~prog_mask))
        else $error("alternate function lost pin direction");

    chk_drive_latch: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        I_ALT_EN == '0 |=> O_PIN == $past(latch_q))
        else $error("pin not driven from latch");

    chk_wake_needs_sleep: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        !sleep_q |-> !O_WAKE)
        else $error("wake while awake");

    chk_sleep_clear_flag: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        sleep_q && flag_q && !(take && I_AVS_WRITE) |=> !sleep_q)
        else $error("sleep kept after flag");

    chk_sync_stage: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        1'b1 |=> pins_q == $past(sync1_q))
        else $error("second stage skipped");

    chk_readdata_hold: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        !(I_AVS_READ && bus_q == BPC_IDLE) |=> $stable(O_AVS_READDATA))
        else $error("read data moved without read");

    chk_lvp_no_change: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        lvp_q |-> !part[PROG_PIN])
        else $error("programming pin in change compare");

    chk_output_no_change: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        (is_out & part) == '0)
        else $error("output pin in change compare");
endmodule

// *** testbench/bpc_pins.sv ***
// external pin model: switches, weak pull-ups and floating lines
`timescale 1ns/100ps
module bpc_pins (
    input wire logic i_clk, // clock for the float pattern
    input wire logic [7:0] i_drv, // device drive value
    input wire logic [7:0] i_oe_n, // device drives when low
    input wire logic [7:0] i_pu, // weak pull-up on
    input wire logic [7:0] i_ext_val, // switch level
    input wire logic [7:0] i_ext_en, // switch closed
    output logic [7:0] o_pin // resolved pin level
);
    logic [7:0] float_q = 8'h55;
    // a floating line wanders, so a stale level is never read
    always @(posedge i_clk) float_q <= ~float_q;
    always_comb begin
        for (int b = 0; b < 8; b++) begin
            if (!i_oe_n[b]) o_pin[b] = i_drv[b];
            else if (i_ext_en[b]) o_pin[b] = i_ext_val[b];
            else if (i_pu[b]) o_pin[b] = 1'b1;
            else o_pin[b] = float_q[b];
        end
    end
endmodule

// *** testbench/tb.sv ***
// self-checking bench for the bidirectional port
`timescale 1ns/100ps
module tb;
    import bpc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic por = 1'b1;
    logic [7:0] addr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, q;
    logic waitreq, flag, wake, low_volt_prog_enable, seen;
    logic [7:0] pin, drv, oe_n, pu, alt_in;
    logic [7:0] ext_val = 8'h00;
    logic [7:0] ext_en = 8'hff;
    logic [7:0] alt_en = 8'h00;
    logic [7:0] alt_out = 8'h00;
    logic [7:0] alt_oe = 8'h00;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    always #4 clk = ~clk;
    bpc_port uut (.I_CORE_CLK(clk), .I_RST(rst), .I_POR(por), .I_AVS_ADDRESS(addr),
        .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata),
        .I_AVS_BYTEENABLE(4'h1), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq),
        .I_PIN(pin), .O_PIN(drv), .O_PIN_OE_N(oe_n), .O_PULLUP_EN(pu), .I_ALT_EN(alt_en),
        .I_ALT_OUT(alt_out), .I_ALT_OE(alt_oe), .O_ALT_IN(alt_in), .O_CHANGE_FLAG(flag),
        .O_WAKE(wake), .O_LVP_ACTIVE(low_volt_prog_enable));
    bpc_pins u_pins (.i_clk(clk), .i_drv(drv), .i_oe_n(oe_n), .i_pu(pu),
        .i_ext_val(ext_val), .i_ext_en(ext_en), .o_pin(pin));
    // ****************
    // shared tasks
    // ****************
    task chk(input string name, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, e, s);
        end
    endtask
    // request held until waitrequest is sampled low
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        rd <= ~w;
        wr <= w;
        wdata <= {24'h0, d};
        @(posedge clk);
        while (waitreq !== 1'b0) @(posedge clk);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        // second edge lets registered outputs settle before callers look
        repeat (2) @(posedge clk);
    endtask
    task test_done;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ****************
    // scenarios
    // ****************
    task t_reset;
        bus(0, IDX_CONFIG, 8'h00);
        chk("config", q, 32'hff);
        bus(0, IDX_DIRECTION, 8'h00);
        chk("direction", q, 32'hff);
        chk("oe_n", oe_n, 8'hff);
        chk("pullup", pu, 8'h00);
        bus(0, 8'h10, 8'h00);
        chk("unmapped", q, 32'h0);
        $display("reset test done");
    endtask
    task t_drive;
        bus(1, IDX_DIRECTION, 8'hf0);
        bus(1, IDX_PORT_DATA, 8'ha5);
        chk("oe_n", oe_n, 8'hf0);
        chk("drive", drv[3:0], 4'h5);
        ext_val <= 8'h30;
        repeat (4) @(posedge clk);
        bus(0, IDX_PORT_DATA, 8'h00);
        chk("pins read", q, 32'h35);
        chk("alt in", alt_in, 8'h35);
        bus(1, IDX_PORT_DATA, 8'h0f);
        bus(1, IDX_DIRECTION, 8'h00);
        chk("whole latch", drv, 8'h0f);
        bus(1, IDX_DIRECTION, 8'hf0);
        repeat (4) @(posedge clk);
        bus(0, IDX_PORT_DATA, 8'h00);
        bus(1, IDX_INT_CTRL, 8'h00);
        chk("flag after settle", flag, 1'b0);
        $display("drive test done");
    endtask
    task t_pullup;
        bus(1, IDX_CONFIG, 8'h7f);
        chk("pullup", pu, 8'hf0);
        ext_en <= 8'h00;
        repeat (4) @(posedge clk);
        bus(0, IDX_PORT_DATA, 8'h00);
        chk("pulled pins", q, 32'hff);
        bus(1, IDX_SYS_CTRL, 8'h01);
        chk("lvp", low_volt_prog_enable, 1'b1);
        chk("lvp pullup", pu, 8'he0);
        bus(1, IDX_SYS_CTRL, 8'h00);
        ext_en <= 8'hff;
        ext_val <= 8'h00;
        bus(1, IDX_CONFIG, 8'hff);
        chk("pullup off", pu, 8'h00);
        repeat (4) @(posedge clk);
        bus(0, IDX_PORT_DATA, 8'h00);
        bus(1, IDX_INT_CTRL, 8'h00);
        $display("pullup test done");
    endtask
    task t_change;
        bus(1, IDX_DIRECTION, 8'hff);
        ext_val <= 8'h0f;
        repeat (6) @(posedge clk);
        chk("lower pins", flag, 1'b0);
        bus(1, IDX_DIRECTION, 8'h7f);
        bus(1, IDX_PORT_DATA, 8'h8f);
        repeat (6) @(posedge clk);
        chk("output pin", flag, 1'b0);
        bus(1, IDX_DIRECTION, 8'hff);
        repeat (4) @(posedge clk);
        bus(0, IDX_PORT_DATA, 8'h00);
        bus(1, IDX_INT_CTRL, 8'h00);
        chk("flag idle", flag, 1'b0);
        ext_val <= 8'h4f;
        repeat (6) @(posedge clk);
        chk("flag set", flag, 1'b1);
        bus(1, IDX_INT_CTRL, 8'h00);
        chk("flag held", flag, 1'b1);
        bus(0, IDX_PORT_DATA, 8'h00);
        chk("pins read", q, 32'h4f);
        bus(1, IDX_INT_CTRL, 8'h00);
        bus(0, IDX_INT_CTRL, 8'h00);
        chk("flag clear", q, 32'h0);
        $display("change test done");
    endtask
    task t_wake;
        seen = 1'b0;
        bus(1, IDX_SYS_CTRL, 8'h02);
        ext_val <= 8'h0f;
        repeat (8) begin
            @(posedge clk);
            seen = seen | wake;
        end
        chk("wake", seen, 1'b1);
        bus(0, IDX_SYS_CTRL, 8'h00);
        chk("sleep cleared", q, 32'h0);
        bus(0, IDX_PORT_DATA, 8'h00);
        bus(1, IDX_INT_CTRL, 8'h00);
        alt_en <= 8'h01;
        alt_oe <= 8'h01;
        alt_out <= 8'h01;
        repeat (3) @(posedge clk);
        chk("alt oe", oe_n[0], 1'b0);
        chk("alt out", drv[0], 1'b1);
        $display("wake test done");
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            test_done();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        por <= 1'b0;
        @(posedge clk);
        t_reset();
        t_drive();
        t_pullup();
        t_change();
        t_wake();
        test_done();
    end
endmodule
